// ### core/eight_bit_timer_counter.sv
`timescale 1ns/10ps
`include "timer_defs.svh"
// Summary of operation
// - Clock select: stop, clock, four divides, pin edges
// - Divided ticks come from shared 10-bit prescaler
// - Every tap derived straight from core clock
// - One eight-bit timer or event counter
// - Up-counter readable and writable any time
// - After write, counting resumes next tick
// - Pin synchronised, then selected edge detected
// - Pin counted regardless of its direction
// - Overflow sets flag at bit one
// - Vector taken clears overflow flag
// - Writing one clears flag, zero keeps
// - Interrupt needs global enable, enable, flag
// - Unused register bits read as zero
module eight_bit_timer_counter
  import timer_pkg::*;
#(
  parameter int COUNT_WIDTH = 8, // Counter width
  parameter int PRESCALE_WIDTH = 10 // Prescaler width
) (
  input wire logic clk, // Core clock, 25 MHz
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic [3:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte enables
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall request
  input wire logic external_count_pin, // Count pin level, any direction
  input wire logic global_irq_enable, // Processor global interrupt enable
  input wire logic irq_vector_taken, // Pulse when overflow vector executes
  output logic irq // Overflow interrupt request, level
);
  logic rst_s1_reg; // Reset release stage one
  logic rst_n_sync; // Reset release stage two
  timer_state_s state_reg; // Prescaler, timer registers and bus state
  timer_state_s state_next; // Next state
  logic pin_rise; // Synchronised rising edge
  logic pin_fall; // Synchronised falling edge
  logic tick; // Counter advance enable
  logic wr_req; // Write accepted this cycle
  logic rd_req; // Read accepted this cycle
  logic lane0; // Low byte enabled
  logic [PRESCALE_WIDTH-1:0] pre_inc; // Prescaler plus one

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_reg <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_sync <= rst_s1_reg;
    end
  end

  // Pin synchroniser and edge finder; pin direction is not consulted
  pin_edge_detect u_edge (
    .clk(clk),
    .rst_n(rst_n_sync),
    .pin(external_count_pin),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // Bus qualifiers: one cycle stall on reads, writes accepted at once
  assign wr_req = avs_write;
  assign rd_req = avs_read & state_reg.rvalid;
  assign lane0 = avs_byteenable[0];
  assign pre_inc = state_reg.prescale + {{(PRESCALE_WIDTH-1){1'b0}}, 1'b1};

  // Tick select from prescaler carry points and pin edges
  always_comb begin
    tick = 1'b0;
    case (state_reg.clock_select)
      CS_STOP: tick = 1'b0;
      CS_CLK: tick = 1'b1;
      // Each tap fires when its low bits are all ones, off the free-running count
      CS_DIV8: tick = &state_reg.prescale[`TAP_DIV8:0];
      CS_DIV64: tick = &state_reg.prescale[`TAP_DIV64:0];
      CS_DIV256: tick = &state_reg.prescale[`TAP_DIV256:0];
      CS_DIV1024: tick = &state_reg.prescale[`TAP_DIV1024:0];
      CS_EXT_FALL: tick = pin_fall;
      CS_EXT_RISE: tick = pin_rise;
      default: tick = 1'b0;
    endcase
  end

  // Next-state logic for prescaler, registers and bus
  always_comb begin
    state_next = state_reg;
    // Shared prescaler runs on every core clock
    state_next.prescale = pre_inc;
    // Read data presented one cycle after request
    state_next.rvalid = avs_read & ~state_reg.rvalid;
    if (avs_read & ~state_reg.rvalid) begin
      case (avs_address)
        `OFS_COUNT_CONTROL: state_next.rdata = {5'h00, state_reg.clock_select};
        `OFS_COUNT_VALUE: state_next.rdata = state_reg.count;
        `OFS_IRQ_MASK: state_next.rdata = {6'h00, state_reg.overflow_irq_enable, 1'b0};
        `OFS_IRQ_FLAG: state_next.rdata = {6'h00, state_reg.overflow_flag, 1'b0};
        default: state_next.rdata = 8'h00;
      endcase
    end
    // Counting; the eight-bit wrap marks overflow
    if (tick) begin
      state_next.count = state_reg.count + 8'h01;
      if (state_reg.count == 8'hFF) begin
        state_next.overflow_flag = 1'b1;
      end
    end
    // Hardware clear when the vector is taken, unless a new overflow lands
    if (irq_vector_taken && !(tick && state_reg.count == 8'hFF)) begin
      state_next.overflow_flag = 1'b0;
    end
    // Software writes
    if (wr_req && lane0) begin
      case (avs_address)
        `OFS_COUNT_CONTROL: state_next.clock_select = clock_select_e'(avs_writedata[`CS_MSB:`CS_LSB]);
        // Written value wins over this cycle's tick; next tick advances it
        `OFS_COUNT_VALUE: state_next.count = avs_writedata[7:0];
        `OFS_IRQ_MASK: state_next.overflow_irq_enable = avs_writedata[`OVF_BIT];
        `OFS_IRQ_FLAG: begin
          // Write one clears, zero keeps; a simultaneous overflow wins
          if (avs_writedata[`OVF_BIT] && !(tick && state_reg.count == 8'hFF)) begin
            state_next.overflow_flag = 1'b0;
          end
        end
        default: state_next.count = state_next.count;
      endcase
    end
  end

  // Register all state
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state_reg.prescale <= `RST_PRESCALE;
      state_reg.clock_select <= CS_STOP;
      state_reg.count <= `RST_COUNT;
      state_reg.overflow_irq_enable <= 1'b0;
      state_reg.overflow_flag <= 1'b0;
      state_reg.rdata <= 8'h00;
      state_reg.rvalid <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Bus outputs
  assign avs_waitrequest = avs_read & ~state_reg.rvalid;
  assign avs_readdata = {24'h000000, state_reg.rdata};
  // Interrupt request gating
  assign irq = global_irq_enable & state_reg.overflow_irq_enable & state_reg.overflow_flag;
endmodule : eight_bit_timer_counter

// ### core/pin_edge_detect.sv
`timescale 1ns/10ps
`include "timer_defs.svh"
module pin_edge_detect
  import timer_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic pin, // External count pin
  output logic rise, // One-cycle pulse on rising edge
  output logic fall // One-cycle pulse on falling edge
);
  edge_state_s state_reg; // Synchroniser and history
  edge_state_s state_next; // Next value

  // Two-stage sync then history stage for edge compare
  always_comb begin
    state_next = state_reg;
    state_next.sync = {state_reg.sync[1:0], pin};
    state_next.rst_n_s1 = 1'b0;
    state_next.rst_n_s2 = 1'b0;
  end

  // Register the state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Edges compare only second and third stages
  assign rise = state_reg.sync[1] & ~state_reg.sync[2];
  assign fall = ~state_reg.sync[1] & state_reg.sync[2];
endmodule : pin_edge_detect

// ### dv/count_pin_model.sv
`timescale 1ns/10ps
module count_pin_model (
  input wire logic clk, // Core clock
  input wire logic fire, // Toggle request
  output logic pin // External count pin level
);
  logic level_reg = 1'h0; // Pin level
  assign pin = level_reg;
  // One toggle per clock, so transitions stay a full period apart
  always @(posedge clk) begin
    if (fire) begin
      level_reg <= ~level_reg;
    end
  end
endmodule : count_pin_model

// ### dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import timer_pkg::*;
  logic clk = 1'h0, nrst = 1'h0, avs_read = 1'h0, avs_write = 1'h0, fire = 1'h0;
  logic global_irq_enable = 1'h0, irq_vector_taken = 1'h0, avs_waitrequest, irq, external_count_pin;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  int fail_count = 0, samples_checked = 0, cyc = 0;
  int div[5] = '{1, 8, 64, 256, 1024};
  eight_bit_timer_counter dut (.clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .external_count_pin, .global_irq_enable,
    .irq_vector_taken, .irq);
  count_pin_model pin_src (.clk(clk), .fire(fire), .pin(external_count_pin));
  always #20 clk = ~clk;
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 9000) begin
      fail_count++;
      results();
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, s, e);
    end
  endtask : chk
  // Bus cycle held until waitrequest is sampled low at a rising edge
  task xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
    avs_read <= ~w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= 4'hF;
    @(posedge clk);
    while (avs_waitrequest) begin
      @(posedge clk);
    end
    // Read data taken at the accepting edge, then the request is released
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge clk);
  endtask : xfer
  task rd(input logic [3:0] a, input logic [31:0] e);
    xfer(1'h0, a, 8'h00);
    chk(q, e);
  endtask : rd
  task results();
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 4; i++) rd(4'(i * 4), 32'h0);
    xfer(1'h1, 4'h2, 8'hFF);
    rd(4'h2, 32'h0);
    xfer(1'h1, 4'h0, 8'hF8);
    rd(4'h0, 32'h0);
    xfer(1'h1, 4'h8, 8'hFD);
    rd(4'h8, 32'h0);
    xfer(1'h1, 4'h4, 8'hA5);
    rd(4'h4, 32'hA5);
    // Core clock and each divide run two of their ticks exactly
    for (int i = 0; i < 5; i++) begin
      xfer(1'h1, 4'h4, 8'h00);
      xfer(1'h1, 4'h0, 8'(i + 1));
      repeat (2 * div[i] - 2) @(posedge clk);
      xfer(1'h1, 4'h0, 8'h00);
      rd(4'h4, 32'h2);
    end
    xfer(1'h1, 4'h4, 8'hFF);
    xfer(1'h1, 4'h0, 8'h01);
    xfer(1'h1, 4'h0, 8'h00);
    rd(4'h4, 32'h1);
    rd(4'hC, 32'h2);
    xfer(1'h1, 4'h8, 8'h02);
    global_irq_enable <= 1'h1;
    @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    @(posedge clk);
    global_irq_enable <= 1'h0;
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    @(posedge clk);
    xfer(1'h1, 4'hC, 8'hFD);
    rd(4'hC, 32'h2);
    xfer(1'h1, 4'hC, 8'h02);
    rd(4'hC, 32'h0);
    xfer(1'h1, 4'h0, 8'h01);
    repeat (254) @(posedge clk);
    xfer(1'h1, 4'h0, 8'h00);
    rd(4'hC, 32'h2);
    irq_vector_taken <= 1'h1;
    @(posedge clk);
    irq_vector_taken <= 1'h0;
    rd(4'hC, 32'h0);
    // Pin edges, rising then falling mode
    for (int e = 0; e < 2; e++) begin
      xfer(1'h1, 4'h4, 8'h00);
      xfer(1'h1, 4'h0, 8'(7 - e));
      fire <= 1'h1;
      repeat (6) @(posedge clk);
      fire <= 1'h0;
      repeat (4) @(posedge clk);
      xfer(1'h1, 4'h0, 8'h00);
      rd(4'h4, 32'h3);
    end
    results();
  end
endmodule : tb_top

// ### dv/timer_checker.sv
`timescale 1ns/10ps
module timer_checker #(
  parameter int COUNT_WIDTH = 8, // Counter width
  parameter int PRESCALE_WIDTH = 10 // Prescaler width
) (
  input wire logic clk, // Core clock
  input wire logic nrst, // Reset, active low
  input wire logic [3:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte enables
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest, // Stall
  input wire logic external_count_pin, // Count pin
  input wire logic global_irq_enable, // Global enable
  input wire logic irq_vector_taken, // Vector pulse
  input wire logic irq // Interrupt
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Read completing in this cycle
  wire logic done = avs_read & ~avs_waitrequest;
  // One stall cycle, then the answer
  sequence s_wait; avs_waitrequest ##1 !avs_waitrequest; endsequence
  property p_rd_wait; $rose(avs_read) |-> s_wait; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read stall wrong");
  property p_wr_go; avs_write |-> !avs_waitrequest; endproperty
  a_wr_go: assert property (p_wr_go) else $error("write stalled");
  property p_idle; !avs_read |-> !avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("idle stall");
  property p_hi0; done |-> avs_readdata[31:8] == 24'h0; endproperty
  a_hi0: assert property (p_hi0) else $error("upper read bits set");
  property p_rsvd; done |-> (avs_readdata[7:0] & (avs_address == 4'h0 ? 8'hF8 : avs_address[3] ? 8'hFD : 8'h00)) == 8'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("unused bit set");
  property p_unmap; done && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
  property p_stable; !avs_read ##1 !avs_read |-> $stable(avs_readdata); endproperty
  a_stable: assert property (p_stable) else $error("read data moved");
  property p_irq_gie; irq |-> global_irq_enable; endproperty
  a_irq_gie: assert property (p_irq_gie) else $error("irq without global enable");
  property p_irq_hold; irq && !irq_vector_taken && !avs_write ##1 global_irq_enable |-> irq; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("flag not sticky");
endmodule : timer_checker
bind eight_bit_timer_counter timer_checker #(.COUNT_WIDTH(COUNT_WIDTH), .PRESCALE_WIDTH(PRESCALE_WIDTH)) u_chk (
  .clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .external_count_pin, .global_irq_enable, .irq_vector_taken, .irq);

// ### inc/timer_defs.svh
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH
// Word offsets (byte addresses on the Avalon bus)
`define OFS_COUNT_CONTROL 4'h0
`define OFS_COUNT_VALUE 4'h4
`define OFS_IRQ_MASK 4'h8
`define OFS_IRQ_FLAG 4'hC
// Field positions
`define CS_LSB 0
`define CS_MSB 2
`define OVF_BIT 1
// Reset values
`define RST_CS 3'h0
`define RST_COUNT 8'h00
`define RST_PRESCALE 10'h000
// Prescaler tap positions: bit n toggles every 2**n cycles, wraps at 2**(n+1)
`define TAP_DIV8 2
`define TAP_DIV64 5
`define TAP_DIV256 7
`define TAP_DIV1024 9
`endif

// ### inc/timer_pkg.sv
package timer_pkg;
  typedef enum logic [2:0] {
    CS_STOP = 3'b000,
    CS_CLK = 3'b001,
    CS_DIV8 = 3'b010,
    CS_DIV64 = 3'b011,
    CS_DIV256 = 3'b100,
    CS_DIV1024 = 3'b101,
    CS_EXT_FALL = 3'b110,
    CS_EXT_RISE = 3'b111
  } clock_select_e;

  typedef struct packed {
    logic [2:0] sync;
    logic rst_n_s1;
    logic rst_n_s2;
  } edge_state_s;

  typedef struct packed {
    logic [9:0] prescale;
    clock_select_e clock_select;
    logic [7:0] count;
    logic overflow_irq_enable;
    logic overflow_flag;
    logic [7:0] rdata;
    logic rvalid;
  } timer_state_s;
endpackage : timer_pkg
